// ### ebtcc_compare.sv
`timescale 1ns/1ps
module ebtcc_compare
	import ebtcc_pkg::*;
#(
	parameter int W = CNT_W
)
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic tick_in,
	input wire logic [W-1:0] count_in,
	input wire logic dir_up_in,
	input wire logic wr_in,
	input wire logic [W-1:0] wr_data_in,
	input wire logic buffered_in,
	input wire logic update_in,
	input wire logic wrap_in,
	input wire logic fast_pwm_in,
	input wire logic phase_pwm_in,
	input wire logic [1:0] com_in,
	output logic [W-1:0] active_out,
	output logic match_out,
	output logic wave_out
);
	logic [W-1:0] buf_q;
	logic inv;

	assign inv = com_in[0];
	assign match_out = tick_in && (count_in == active_out);

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			buf_q <= W'(CMP_RESET);
		else if (wr_in)
			buf_q <= wr_data_in;
	end

	// Immediate load, or copy at the mode's update point
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			active_out <= W'(CMP_RESET);
		else if (!buffered_in && wr_in)
			active_out <= wr_data_in;
		else if (buffered_in && update_in)
			active_out <= buf_q;
	end

	// Output polarity and action set by the output mode
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			wave_out <= 1'b0;
		else if (com_in == COM_OFF)
			wave_out <= wave_out;
		else if (com_in == COM_TOGGLE)
			wave_out <= match_out ? !wave_out : wave_out;
		else if (fast_pwm_in)
		begin
			if (wrap_in)
				wave_out <= !inv;
			else if (match_out)
				wave_out <= inv;
		end
		else if (phase_pwm_in)
		begin
			if (match_out)
				wave_out <= dir_up_in ? inv : !inv;
		end
		else if (match_out)
			wave_out <= inv;
	end

	a_buffer_holds:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		buffered_in && !update_in |=> $stable(active_out))
		else $error("compare value changed outside update point");

	a_immediate_load:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		!buffered_in && wr_in |=> active_out == $past(wr_data_in))
		else $error("immediate compare write lost");
endmodule : ebtcc_compare

// ### ebtcc_core.sv
`timescale 1ns/1ps
module ebtcc_core
	import ebtcc_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic timer_power_gate_in,
	input wire logic [2:0] clock_select_field_in,
	input wire logic [1:0] ctrl_a_wave_low_in,
	input wire logic ctrl_b_wave_high_in,
	input wire logic [1:0] compare_output_mode_a_in,
	input wire logic [1:0] compare_output_mode_b_in,
	input wire logic async_clock_select_in,
	input wire logic meter_clock_select_in,
	input wire logic crystal_osc_in,
	input wire logic meter_reading_clock_pin_in,
	input wire logic prescaler_reset_in,
	input wire logic count_wr_in,
	input wire logic [CNT_W-1:0] count_wr_data_in,
	input wire logic compare_a_wr_in,
	input wire logic [CNT_W-1:0] compare_a_data_in,
	input wire logic compare_b_wr_in,
	input wire logic [CNT_W-1:0] compare_b_data_in,
	input wire logic [2:0] flag_clear_in,
	input wire logic [2:0] timer_mask_reg_in,
	output logic [CNT_W-1:0] timer_count_value_out,
	output logic [CNT_W-1:0] compare_value_a_out,
	output logic [CNT_W-1:0] compare_value_b_out,
	output logic [2:0] timer_flag_reg_out,
	output logic [2:0] irq_req_out,
	output logic count_top_out,
	output logic count_bottom_out,
	output logic count_up_out,
	output logic compare_output_a_out
);
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	ebtcc_dir_e dir_q;
	ebtcc_dir_e dir_d;
	logic [2:0] flag_q;
	logic [2:0] flag_d;
	logic [2:0] mode;
	logic osc_prev_q;
	logic meter_prev_q;
	logic src_tick;
	logic tick;
	logic [CNT_W-1:0] top_val;
	logic phase_mode;
	logic fast_mode;
	logic buffered;
	logic ovf_evt;
	logic upd_evt;
	logic wrap_evt;
	logic [NUM_CMP-1:0] cmp_wr;
	logic [CNT_W-1:0] cmp_data [NUM_CMP];
	logic [CNT_W-1:0] cmp_active [NUM_CMP];
	logic [1:0] cmp_com [NUM_CMP];
	logic [NUM_CMP-1:0] cmp_match;
	logic [NUM_CMP-1:0] cmp_wave;

	// Mode field assembled from both control registers
	assign mode = {ctrl_b_wave_high_in, ctrl_a_wave_low_in};
	assign phase_mode = ebtcc_is_phase(mode);
	assign fast_mode = ebtcc_is_fast(mode);
	assign buffered = phase_mode || fast_mode;
	assign top_val = ebtcc_top_cmp(mode) ? cmp_active[0] : CNT_MAX;

	// Edge detect on the asynchronous source pins
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			osc_prev_q <= 1'b0;
			meter_prev_q <= 1'b0;
		end
		else
		begin
			osc_prev_q <= crystal_osc_in;
			meter_prev_q <= meter_reading_clock_pin_in;
		end
	end

	always_comb
	begin
		if (!async_clock_select_in)
			src_tick = 1'b1;
		else if (meter_clock_select_in)
			src_tick = meter_reading_clock_pin_in && !meter_prev_q;
		else
			src_tick = crystal_osc_in && !osc_prev_q;
	end

	ebtcc_prescaler #(
		.W(PS_W)
	) u_prescaler (
		.sys_clk_in(sys_clk_in),
		.sys_rst_in(sys_rst_in),
		.src_tick_in(src_tick && !timer_power_gate_in),
		.ps_reset_in(prescaler_reset_in),
		.clock_select_field_in(clock_select_field_in),
		.tick_out(tick)
	);

	// Next count; output mode takes no part here
	always_comb
	begin
		count_d = count_q;
		dir_d = dir_q;
		ovf_evt = 1'b0;
		upd_evt = 1'b0;
		wrap_evt = 1'b0;
		if (tick)
		begin
			if (phase_mode)
			begin
				if (dir_q == DIR_UP)
				begin
					if (count_q == top_val)
					begin
						dir_d = DIR_DOWN;
						count_d = count_q - CNT_ONE;
						upd_evt = 1'b1;
					end
					else
						count_d = count_q + CNT_ONE;
				end
				else
				begin
					if (count_q == CNT_BOTTOM)
					begin
						dir_d = DIR_UP;
						count_d = count_q + CNT_ONE;
					end
					else
					begin
						count_d = count_q - CNT_ONE;
						ovf_evt = (count_d == CNT_BOTTOM);
					end
				end
			end
			else
			begin
				dir_d = DIR_UP;
				if ((mode == MODE_CTC || fast_mode) && count_q == top_val)
				begin
					count_d = CNT_BOTTOM;
					wrap_evt = 1'b1;
				end
				else
					count_d = count_q + CNT_ONE;
				if (mode == MODE_FAST_CMP)
				begin
					ovf_evt = (count_q == top_val);
					upd_evt = wrap_evt;
				end
				else
				begin
					ovf_evt = (count_q == CNT_MAX);
					upd_evt = (mode == MODE_FAST_MAX) && (count_q == top_val);
				end
			end
		end
		if (count_wr_in)
		begin
			count_d = count_wr_data_in;
			ovf_evt = 1'b0;
			wrap_evt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			count_q <= CNT_BOTTOM;
		else
			count_q <= count_d;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			dir_q <= DIR_UP;
		else
			dir_q <= dir_d;
	end

	// Compare channels; channel B's waveform stays internal
	assign cmp_wr = {compare_b_wr_in, compare_a_wr_in};
	assign cmp_data[0] = compare_a_data_in;
	assign cmp_data[1] = compare_b_data_in;
	assign cmp_com[0] = compare_output_mode_a_in;
	assign cmp_com[1] = compare_output_mode_b_in;

	generate
		for (genvar i = 0; i < NUM_CMP; i++)
		begin : g_cmp
			ebtcc_compare #(
				.W(CNT_W)
			) u_cmp (
				.sys_clk_in(sys_clk_in),
				.sys_rst_in(sys_rst_in),
				.tick_in(tick),
				.count_in(count_q),
				.dir_up_in(dir_q == DIR_UP),
				.wr_in(cmp_wr[i]),
				.wr_data_in(cmp_data[i]),
				.buffered_in(buffered),
				.update_in(upd_evt),
				.wrap_in(wrap_evt),
				.fast_pwm_in(fast_mode),
				.phase_pwm_in(phase_mode),
				.com_in(cmp_com[i]),
				.active_out(cmp_active[i]),
				.match_out(cmp_match[i]),
				.wave_out(cmp_wave[i])
			);
		end
	endgenerate

	// Sticky flags, set wins over a same-cycle clear
	always_comb
	begin
		flag_d = flag_q & ~flag_clear_in;
		flag_d[FLAG_OVF] = flag_d[FLAG_OVF] | ovf_evt;
		flag_d[FLAG_CMP_A] = flag_d[FLAG_CMP_A] | cmp_match[0];
		flag_d[FLAG_CMP_B] = flag_d[FLAG_CMP_B] | cmp_match[1];
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			flag_q <= FLAG_RESET;
		else
			flag_q <= flag_d;
	end

	assign timer_count_value_out = count_q;
	assign compare_value_a_out = cmp_active[0];
	assign compare_value_b_out = cmp_active[1];
	assign timer_flag_reg_out = flag_q;
	assign irq_req_out = flag_q & timer_mask_reg_in;
	assign count_top_out = (count_q == CNT_MAX);
	assign count_bottom_out = (count_q == CNT_BOTTOM);
	assign count_up_out = (dir_q == DIR_UP);
	assign compare_output_a_out = cmp_wave[0];

	sequence s_phase_at_top;
		phase_mode && tick && dir_q == DIR_UP && count_q == top_val && count_q != CNT_BOTTOM && !count_wr_in;
	endsequence

	sequence s_phase_turned;
		dir_q == DIR_DOWN && count_q == $past(top_val) - CNT_ONE;
	endsequence

	a_stop_freeze:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		clock_select_field_in == CS_STOP && !count_wr_in [*2] |=> $stable(count_q))
		else $error("counter moved while stopped");

	a_cpu_write_wins:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		count_wr_in |=> timer_count_value_out == $past(count_wr_data_in))
		else $error("counter write did not take effect");

	a_normal_wrap:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		mode == MODE_NORMAL && tick && count_q == CNT_MAX && !count_wr_in
		|=> count_q == CNT_BOTTOM && timer_flag_reg_out[FLAG_OVF])
		else $error("normal wrap or overflow wrong");

	a_ctc_clear:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		mode == MODE_CTC && tick && count_q == cmp_active[0] && !count_wr_in
		|=> count_q == CNT_BOTTOM && timer_flag_reg_out[FLAG_CMP_A])
		else $error("compare clear not done");

	a_phase_turn:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		s_phase_at_top |=> s_phase_turned)
		else $error("phase mode did not turn at top");

	a_flag_sticky:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		timer_flag_reg_out[FLAG_OVF] && !flag_clear_in[FLAG_OVF] |=> timer_flag_reg_out[FLAG_OVF])
		else $error("overflow flag dropped without clear");

	a_irq_needs_flag:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		ovf_evt ##1 timer_mask_reg_in[FLAG_OVF] |-> irq_req_out[FLAG_OVF])
		else $error("enabled overflow raised no request");

	a_count_step:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		tick && !count_wr_in && !phase_mode |=> count_q == CNT_BOTTOM || count_q == $past(count_q) + CNT_ONE)
		else $error("single slope step wrong");
endmodule : ebtcc_core

// ### ebtcc_core_tb.sv
`timescale 1ns/1ps
module ebtcc_core_tb
	import ebtcc_pkg::*;
;
	logic clk, rst, gate, wh, asel, msel, xosc, mpin, psr, cwr, awr, bwr;
	logic [2:0] cs, fclr, mask, flg, irq;
	logic [1:0] wl, coma, comb;
	logic [7:0] cwd, awd, bwd, cnt, cva, cvb;
	logic top, bot, up, wav;
	int err_count, checks, cycles;

	ebtcc_core u_dut (.sys_clk_in(clk), .sys_rst_in(rst), .timer_power_gate_in(gate),
		.clock_select_field_in(cs), .ctrl_a_wave_low_in(wl), .ctrl_b_wave_high_in(wh),
		.compare_output_mode_a_in(coma), .compare_output_mode_b_in(comb), .async_clock_select_in(asel),
		.meter_clock_select_in(msel), .crystal_osc_in(xosc), .meter_reading_clock_pin_in(mpin),
		.prescaler_reset_in(psr), .count_wr_in(cwr), .count_wr_data_in(cwd), .compare_a_wr_in(awr),
		.compare_a_data_in(awd), .compare_b_wr_in(bwr), .compare_b_data_in(bwd), .flag_clear_in(fclr),
		.timer_mask_reg_in(mask), .timer_count_value_out(cnt), .compare_value_a_out(cva),
		.compare_value_b_out(cvb), .timer_flag_reg_out(flg), .irq_req_out(irq), .count_top_out(top),
		.count_bottom_out(bot), .count_up_out(up), .compare_output_a_out(wav));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task finish_test;
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			err_count++;
			finish_test();
		end
	end

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task step;
		@(posedge clk);
		#1;
	endtask : step

	task cfg(input logic [2:0] m, input logic [2:0] c);
		@(posedge clk);
		wl <= m[1:0];
		wh <= m[2];
		cs <= c;
		#1;
	endtask : cfg

	task setc(input logic [7:0] v);
		@(posedge clk);
		cwr <= 1'b1;
		cwd <= v;
		@(posedge clk);
		cwr <= 1'b0;
		#1;
	endtask : setc

	task seta(input logic [7:0] v);
		@(posedge clk);
		awr <= 1'b1;
		awd <= v;
		@(posedge clk);
		awr <= 1'b0;
		#1;
	endtask : seta

	task setb(input logic [7:0] v);
		@(posedge clk);
		bwr <= 1'b1;
		bwd <= v;
		@(posedge clk);
		bwr <= 1'b0;
		#1;
	endtask : setb

	task clrf;
		@(posedge clk);
		fclr <= 3'h7;
		@(posedge clk);
		fclr <= 3'h0;
		#1;
	endtask : clrf

	task wcnt(input logic [7:0] v, input int lim);
		for (int i = 0; i < lim && cnt !== v; i++)
			step();
	endtask : wcnt

	task gap(output int n);
		logic [7:0] p;
		p = cnt;
		n = 0;
		while (cnt === p && n < 3000)
		begin
			step();
			n++;
		end
	endtask : gap

	task edges(input logic on_meter, input int n);
		repeat (n)
		begin
			@(posedge clk);
			xosc <= ~on_meter;
			mpin <= on_meter;
			repeat (4) @(posedge clk);
			xosc <= 1'b0;
			mpin <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (6) step();
	endtask : edges

	task t_reset;
		chk("count", cnt, 8'h00);
		chk("cmp_a", cva, 8'h00);
		chk("flags", flg, 3'h0);
		chk("bottom", bot, 1'b1);
		chk("top", top, 1'b0);
		chk("up", up, 1'b1);
		$display("reset test done");
	endtask : t_reset

	task t_stop;
		cfg(MODE_NORMAL, 3'h0);
		setc(8'hFE);
		repeat (20) step();
		chk("count", cnt, 8'hFE);
		setc(8'hFF);
		chk("top", top, 1'b1);
		chk("bottom", bot, 1'b0);
		$display("stop test done");
	endtask : t_stop

	task t_normal;
		setc(8'hFD);
		clrf();
		mask <= 3'h1;
		cfg(MODE_NORMAL, 3'h1);
		wcnt(8'h00, 10);
		chk("count", cnt, 8'h00);
		chk("ovf", flg[0], 1'b1);
		chk("irq", irq[0], 1'b1);
		mask <= 3'h0;
		step();
		chk("irq", irq[0], 1'b0);
		setc(8'h40);
		chk("count", cnt, 8'h40);
		step();
		chk("count", cnt, 8'h41);
		clrf();
		wcnt(8'hFE, 300);
		setc(8'h10);
		chk("count", cnt, 8'h10);
		chk("ovf", flg[0], 1'b0);
		$display("normal test done");
	endtask : t_normal

	task t_ctc;
		int mx, tg, wr;
		logic w;
		cfg(MODE_CTC, 3'h0);
		coma <= 2'h1;
		seta(8'h05);
		setb(8'h03);
		chk("cmp_a", cva, 8'h05);
		chk("cmp_b", cvb, 8'h03);
		setc(8'h00);
		clrf();
		cfg(MODE_CTC, 3'h1);
		mx = 0;
		tg = 0;
		wr = 0;
		w = wav;
		for (int i = 0; i < 40; i++)
		begin
			step();
			if (cnt > mx)
				mx = cnt;
			if (cnt === 8'h00)
				wr++;
			if (wav !== w)
				tg++;
			w = wav;
		end
		chk("ctc_max", mx, 16'h0005);
		chk("flag_a", flg[1], 1'b1);
		chk("flag_b", flg[2], 1'b1);
		chk("toggles", tg, wr);
		cfg(MODE_CTC, 3'h0);
		$display("ctc test done");
	endtask : t_ctc

	task t_phase;
		cfg(MODE_PHASE_MAX, 3'h0);
		setc(8'hFD);
		clrf();
		cfg(MODE_PHASE_MAX, 3'h1);
		wcnt(8'hFF, 10);
		step();
		chk("count", cnt, 8'hFE);
		chk("up", up, 1'b0);
		wcnt(8'h00, 300);
		chk("ovf", flg[0], 1'b1);
		step();
		chk("count", cnt, 8'h01);
		$display("phase test done");
	endtask : t_phase

	task t_fast;
		cfg(MODE_FAST_MAX, 3'h0);
		setc(8'h20);
		clrf();
		seta(8'h30);
		chk("cmp_a", cva, 8'h05);
		cfg(MODE_FAST_MAX, 3'h1);
		wcnt(8'h00, 300);
		chk("cmp_a", cva, 8'h30);
		chk("ovf", flg[0], 1'b1);
		$display("fast test done");
	endtask : t_fast

	task t_presc;
		logic [15:0] dv [7];
		int n;
		dv = '{16'h0001, 16'h0008, 16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0400};
		for (int k = 1; k < 8; k++)
		begin
			cfg(MODE_NORMAL, k[2:0]);
			gap(n);
			gap(n);
			chk("divide", n, dv[k - 1]);
		end
		cfg(MODE_NORMAL, 3'h2);
		psr <= 1'b1;
		setc(8'h50);
		repeat (30) step();
		chk("count", cnt, 8'h50);
		psr <= 1'b0;
		$display("prescaler test done");
	endtask : t_presc

	task t_async;
		cfg(MODE_NORMAL, 3'h0);
		asel <= 1'b1;
		msel <= 1'b0;
		setc(8'h00);
		cfg(MODE_NORMAL, 3'h1);
		edges(1'b0, 5);
		chk("count", cnt, 8'h05);
		msel <= 1'b1;
		edges(1'b1, 3);
		chk("count", cnt, 8'h08);
		gate <= 1'b1;
		edges(1'b1, 3);
		chk("count", cnt, 8'h08);
		$display("async test done");
	endtask : t_async

	task t_pwm;
		cfg(MODE_FAST_CMP, 3'h0);
		@(posedge clk);
		gate <= 1'b0;
		asel <= 1'b0;
		coma <= 2'h2;
		seta(8'h06);
		chk("cmp_a", cva, 8'h30);
		setc(8'h2E);
		clrf();
		cfg(MODE_FAST_CMP, 3'h1);
		wcnt(8'h00, 10);
		chk("cmp_a", cva, 8'h06);
		chk("ovf", flg[0], 1'b1);
		chk("wave", wav, 1'b1);
		wcnt(8'h06, 10);
		step();
		chk("count", cnt, 8'h00);
		cfg(MODE_PHASE_CMP, 3'h0);
		setc(8'h04);
		clrf();
		cfg(MODE_PHASE_CMP, 3'h1);
		wcnt(8'h06, 10);
		step();
		chk("count", cnt, 8'h05);
		chk("up", up, 1'b0);
		chk("wave", wav, 1'b0);
		wcnt(8'h00, 20);
		chk("ovf", flg[0], 1'b1);
		step();
		cfg(MODE_PHASE_MAX, 3'h0);
		coma <= 2'h3;
		setc(8'h04);
		cfg(MODE_PHASE_MAX, 3'h1);
		wcnt(8'h07, 10);
		chk("wave", wav, 1'b1);
		wcnt(8'h05, 600);
		chk("wave", wav, 1'b0);
		chk("count", cnt, 8'h05);
		$display("pwm test done");
	endtask : t_pwm

	initial
	begin
		{gate, wh, asel, msel, xosc, mpin, psr, cwr, awr, bwr} = '0;
		{cs, fclr, mask, wl, coma, comb, cwd, awd, bwd} = '0;
		err_count = 0;
		checks = 0;
		cycles = 0;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_stop();
		t_normal();
		t_ctc();
		t_phase();
		t_fast();
		t_presc();
		t_async();
		t_pwm();
		finish_test();
	end
endmodule : ebtcc_core_tb

// ### ebtcc_pkg.sv
package ebtcc_pkg;
	localparam int CNT_W = 8;
	localparam int PS_W = 10;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
	localparam logic [2:0] MODE_CTC = 3'h2;
	localparam logic [2:0] MODE_FAST_MAX = 3'h3;
	localparam logic [2:0] MODE_PHASE_CMP = 3'h5;
	localparam logic [2:0] MODE_FAST_CMP = 3'h7;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMP_A = 1;
	localparam int FLAG_CMP_B = 2;
	localparam int NUM_CMP = 2;
	localparam logic [2:0] FLAG_RESET = 3'h0;
	localparam logic [9:0] PS_MASK_1 = 10'h000;
	localparam logic [9:0] PS_MASK_8 = 10'h007;
	localparam logic [9:0] PS_MASK_32 = 10'h01F;
	localparam logic [9:0] PS_MASK_64 = 10'h03F;
	localparam logic [9:0] PS_MASK_128 = 10'h07F;
	localparam logic [9:0] PS_MASK_256 = 10'h0FF;
	localparam logic [9:0] PS_MASK_1024 = 10'h3FF;
	localparam logic [9:0] PS_RESET = 10'h000;
	typedef enum logic [1:0] {DIR_UP = 2'b01, DIR_DOWN = 2'b10} ebtcc_dir_e;

	function automatic logic ebtcc_is_phase(input logic [2:0] mode);
		ebtcc_is_phase = (mode == MODE_PHASE_MAX) || (mode == MODE_PHASE_CMP);
	endfunction : ebtcc_is_phase

	function automatic logic ebtcc_is_fast(input logic [2:0] mode);
		ebtcc_is_fast = (mode == MODE_FAST_MAX) || (mode == MODE_FAST_CMP);
	endfunction : ebtcc_is_fast

	function automatic logic ebtcc_top_cmp(input logic [2:0] mode);
		ebtcc_top_cmp = (mode == MODE_CTC) || (mode == MODE_PHASE_CMP) || (mode == MODE_FAST_CMP);
	endfunction : ebtcc_top_cmp
endpackage : ebtcc_pkg

// ### ebtcc_prescaler.sv
`timescale 1ns/1ps
module ebtcc_prescaler
	import ebtcc_pkg::*;
#(
	parameter int W = PS_W
)
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic src_tick_in,
	input wire logic ps_reset_in,
	input wire logic [2:0] clock_select_field_in,
	output logic tick_out
);
	logic [W-1:0] ps_q;
	logic [W-1:0] mask;

	// Free running divider advanced by the selected source
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in || ps_reset_in)
			ps_q <= W'(PS_RESET);
		else if (src_tick_in)
			ps_q <= ps_q + W'(1);
	end

	// Division taps 1, 8, 32, 64, 128, 256, 1024
	always_comb
	begin
		case (clock_select_field_in)
			3'h1: mask = W'(PS_MASK_1);
			3'h2: mask = W'(PS_MASK_8);
			3'h3: mask = W'(PS_MASK_32);
			3'h4: mask = W'(PS_MASK_64);
			3'h5: mask = W'(PS_MASK_128);
			3'h6: mask = W'(PS_MASK_256);
			3'h7: mask = W'(PS_MASK_1024);
			default: mask = W'(PS_MASK_1);
		endcase
	end

	// Single-cycle enable, no derived clock
	assign tick_out = src_tick_in && (clock_select_field_in != CS_STOP) && ((ps_q & mask) == mask);

	a_stop_no_tick:
	assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		(clock_select_field_in == CS_STOP) |-> !tick_out)
		else $error("tick issued with clock stopped");
endmodule : ebtcc_prescaler
